// ===== verilog/i2sp_pkg.sv
// shared constants for the two-wire register port and its bus master
package i2sp_pkg;
    localparam logic [6:0] ADDR_BASE = 7'h48;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [7:0] GEN_CALL_RESET = 8'h06;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam logic [1:0] IDX_RESULT = 2'h0;
    localparam logic [1:0] IDX_CONFIG = 2'h1;
    localparam logic [1:0] IDX_LOWER = 2'h2;
    localparam logic [1:0] IDX_UPPER = 2'h3;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'h8583;
    localparam logic [15:0] LOWER_RESET = 16'h8000;
    localparam logic [15:0] UPPER_RESET = 16'h7fff;
    localparam logic [15:0] CODE_POS_FS = 16'h7fff;
    localparam logic [15:0] CODE_NEG_FS = 16'h8000;
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_VDD = 2'h1;
    localparam logic [1:0] STRAP_DATA = 2'h2;
    localparam logic [1:0] STRAP_CLOCK = 2'h3;
    // master register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_DIV = 8'h10;
    localparam int CTRL_GO = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_READ = 3;
    localparam int CTRL_NACK = 4;
    localparam int CTRL_HS = 5;
    // clock at 125 MHz; quarter period of the link clock
    localparam int CLK_MHZ = 125;
    localparam int STD_KHZ = 100;
    localparam logic [15:0] DIV_RESET = 16'((CLK_MHZ * 1000) / (STD_KHZ * 4));
    typedef enum logic [3:0] {
        SL_IDLE = 4'h0, SL_ADDR = 4'h1, SL_ADDR_ACK = 4'h3, SL_PTR = 4'h2,
        SL_PTR_ACK = 4'h6, SL_WDATA = 4'h7, SL_WACK = 4'h5, SL_RDATA = 4'h4,
        SL_RACK = 4'hc, SL_GCMD = 4'hd, SL_GACK = 4'hf, SL_IGNORE = 4'he
    } i2sp_slave_state_t;
    typedef enum logic [2:0] {
        MS_IDLE = 3'h0, MS_START = 3'h1, MS_BIT = 3'h3, MS_ACK = 3'h2,
        MS_STOP = 3'h6, MS_DONE = 3'h7
    } i2sp_master_state_t;
endpackage

// ===== verilog/i2sp_link_if.sv
// two-wire link between the bus master and the register port
`timescale 1ns/1ps
interface i2sp_link_if;
    logic sclOut;
    logic sclOe;
    logic sdaMOut;
    logic sdaMOe;
    logic sdaSOut;
    logic sdaSOe;
    logic scl;
    logic sda;
    assign scl = ~sclOe;
    assign sda = ~(sdaMOe | sdaSOe);
    modport master (output sclOut, output sclOe, output sdaMOut, output sdaMOe,
        input scl, input sda);
    modport slave (output sdaSOut, output sdaSOe, input scl, input sda);
endinterface

// ===== verilog/i2sp_slave.sv
// register port: two-wire target with pointer, four 16-bit registers
// Summary of operation
// - strap pin selects one of four addresses
// - strap level is sampled all the time
// - acknowledge general call, then take command
// - command 06h resets registers, powers down
// - master code not acknowledged, no direction
// - master code enables fast filter until stop
// - standard and fast speeds need no setup
// - never drive the clock line
// - acknowledge pointer byte after write address
// - two data bytes stored, high byte first
// - read sends high then low byte
// - nack, start or stop ends read
// - pointer-only write is accepted
// - pointer kept until next write
// - master always sends pointer in writes
// - index 0 result,1 config,2 lower,3 upper
// - exactly four 16-bit registers visible
// - results are two's complement
// - results clip at full-scale codes
// - general-call reset equals power-up reset
// - result reads zero until first conversion
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module i2sp_slave
    import i2sp_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    i2sp_link_if.slave link,
    input wire logic [1:0] strapSel,
    input wire logic resultValid,
    input wire logic signed [17:0] resultRaw,
    output logic [15:0] configWord,
    output logic [15:0] lowerLimit,
    output logic [15:0] upperLimit,
    output logic powerDown,
    output logic hsMode
);
    logic [1:0] sclSync_q, sdaSync_q, strap0_q, strap1_q;
    logic sclPrev_q, sdaPrev_q;
    i2sp_slave_state_t state_q;
    logic [2:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [1:0] pointer_q;
    logic [15:0] result_q, config_q, lower_q, upper_q, txWord_q;
    logic firstData_q, firstByte_q, sdaDrv_q, hs_q, pd_q, genReset_q, gotBit_q;
    logic [7:0] hiByte_q;
    logic sclRise, sclFall, startSeen, stopSeen;
    logic [6:0] myAddr;

    // clip a wide signed sample into the 16-bit result code
    function automatic logic [15:0] clip(input logic signed [17:0] v);
        if (v > 18'sd32767)
            return CODE_POS_FS;
        else if (v < -18'sd32768)
            return CODE_NEG_FS;
        else
            return v[15:0];
    endfunction

    function automatic logic [15:0] pick(input logic [1:0] idx, input logic [15:0] r,
            input logic [15:0] c, input logic [15:0] lo, input logic [15:0] hi);
        case (idx)
            IDX_RESULT: return r;
            IDX_CONFIG: return c;
            IDX_LOWER: return lo;
            default: return hi;
        endcase
    endfunction

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            strap0_q <= 2'h0;
            strap1_q <= 2'h0;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclSync_q <= {sclSync_q[0], link.scl};
            sdaSync_q <= {sdaSync_q[0], link.sda};
            strap0_q <= strapSel;
            strap1_q <= strap0_q;
            sclPrev_q <= sclSync_q[1];
            sdaPrev_q <= sdaSync_q[1];
        end
    end

    assign sclRise = sclSync_q[1] & ~sclPrev_q;
    assign sclFall = ~sclSync_q[1] & sclPrev_q;
    assign startSeen = sclSync_q[1] & sclPrev_q & sdaPrev_q & ~sdaSync_q[1];
    assign stopSeen = sclSync_q[1] & sclPrev_q & ~sdaPrev_q & sdaSync_q[1];
    assign myAddr = ADDR_BASE | {5'h00, strap1_q};

    // protocol engine; same clock edges serve all speeds
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= SL_IDLE;
            bitCnt_q <= 3'h0;
            shift_q <= 8'h00;
            sdaDrv_q <= 1'b0;
            firstData_q <= 1'b0;
            firstByte_q <= 1'b0;
            txWord_q <= 16'h0000;
            hs_q <= 1'b0;
            genReset_q <= 1'b0;
            gotBit_q <= 1'b0;
        end else begin
            genReset_q <= 1'b0;
            if (stopSeen) begin
                state_q <= SL_IDLE;
                sdaDrv_q <= 1'b0;
                hs_q <= 1'b0;
            end else if (startSeen) begin
                state_q <= SL_ADDR;
                bitCnt_q <= 3'h0;
                sdaDrv_q <= 1'b0;
                firstByte_q <= 1'b1;
                gotBit_q <= 1'b0;
            end else if (sclRise) begin
                case (state_q)
                    SL_ADDR, SL_PTR, SL_WDATA, SL_GCMD: begin
                        shift_q <= {shift_q[6:0], sdaSync_q[1]};
                        bitCnt_q <= bitCnt_q + 3'h1;
                        gotBit_q <= 1'b1;
                    end
                    SL_RACK: begin
                        // stay here on an ack; the next fall starts the low byte
                        if (sdaSync_q[1])
                            state_q <= SL_IGNORE;
                    end
                    default: begin
                    end
                endcase
            end else if (sclFall) begin
                case (state_q)
                    SL_ADDR: begin
                        // the fall that closes a start comes before any bit
                        if (bitCnt_q == 3'h0 && gotBit_q) begin
                            firstByte_q <= 1'b0;
                            if (firstByte_q && shift_q[7:3] == HS_CODE_TOP) begin
                                hs_q <= 1'b1;
                                state_q <= SL_IGNORE;
                            end else if (shift_q[7:1] == myAddr) begin
                                sdaDrv_q <= 1'b1;
                                state_q <= SL_ADDR_ACK;
                                txWord_q <= pick(pointer_q, result_q, config_q,
                                    lower_q, upper_q);
                            end else if (shift_q == {GEN_CALL_ADDR, 1'b0}) begin
                                sdaDrv_q <= 1'b1;
                                state_q <= SL_ADDR_ACK;
                            end else begin
                                state_q <= SL_IGNORE;
                            end
                        end
                    end
                    SL_ADDR_ACK: begin
                        if (shift_q[0]) begin
                            state_q <= SL_RDATA;
                            sdaDrv_q <= ~txWord_q[15];
                            txWord_q <= {txWord_q[14:0], 1'b0};
                            bitCnt_q <= 3'h1;
                        end else begin
                            sdaDrv_q <= 1'b0;
                            bitCnt_q <= 3'h0;
                            state_q <= (shift_q[7:1] == GEN_CALL_ADDR) ? SL_GCMD : SL_PTR;
                        end
                    end
                    SL_PTR, SL_WDATA, SL_GCMD: begin
                        if (bitCnt_q == 3'h0) begin
                            if (state_q == SL_GCMD) begin
                                sdaDrv_q <= 1'b1;
                                state_q <= SL_GACK;
                                genReset_q <= (shift_q == GEN_CALL_RESET);
                            end else begin
                                sdaDrv_q <= 1'b1;
                                state_q <= (state_q == SL_PTR) ? SL_PTR_ACK : SL_WACK;
                            end
                        end
                    end
                    SL_PTR_ACK: begin
                        sdaDrv_q <= 1'b0;
                        firstData_q <= 1'b1;
                        state_q <= SL_WDATA;
                    end
                    SL_WACK: begin
                        sdaDrv_q <= 1'b0;
                        firstData_q <= ~firstData_q;
                        state_q <= firstData_q ? SL_WDATA : SL_IGNORE;
                    end
                    SL_GACK: begin
                        sdaDrv_q <= 1'b0;
                        state_q <= SL_IGNORE;
                    end
                    SL_RDATA: begin
                        if (bitCnt_q == 3'h0) begin
                            sdaDrv_q <= 1'b0;
                            state_q <= SL_RACK;
                        end else begin
                            sdaDrv_q <= ~txWord_q[15];
                            txWord_q <= {txWord_q[14:0], 1'b0};
                            bitCnt_q <= bitCnt_q + 3'h1;
                        end
                    end
                    default: begin
                    end
                endcase
                // after master acks high byte, emit first bit of low byte
                if (state_q == SL_RACK) begin
                    state_q <= SL_RDATA;
                    sdaDrv_q <= ~txWord_q[15];
                    txWord_q <= {txWord_q[14:0], 1'b0};
                    bitCnt_q <= 3'h1;
                end
            end
        end
    end

    // registers; a general-call reset mirrors power-up
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pointer_q <= IDX_RESULT;
            config_q <= CONFIG_RESET;
            lower_q <= LOWER_RESET;
            upper_q <= UPPER_RESET;
            hiByte_q <= 8'h00;
            pd_q <= 1'b1;
        end else if (genReset_q) begin
            pointer_q <= IDX_RESULT;
            config_q <= CONFIG_RESET;
            lower_q <= LOWER_RESET;
            upper_q <= UPPER_RESET;
            pd_q <= 1'b1;
        end else if (sclFall && bitCnt_q == 3'h0) begin
            if (state_q == SL_PTR)
                pointer_q <= shift_q[1:0];
            else if (state_q == SL_WDATA && firstData_q)
                hiByte_q <= shift_q;
            else if (state_q == SL_WDATA) begin
                case (pointer_q)
                    IDX_CONFIG: config_q <= {hiByte_q, shift_q};
                    IDX_LOWER: lower_q <= {hiByte_q, shift_q};
                    IDX_UPPER: upper_q <= {hiByte_q, shift_q};
                    default: begin
                    end
                endcase
                if (pointer_q == IDX_CONFIG)
                    pd_q <= hiByte_q[0];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            result_q <= RESULT_RESET;
        else if (genReset_q)
            result_q <= RESULT_RESET;
        else if (resultValid)
            result_q <= clip(resultRaw);
    end

    // data line only ever pulled low; clock line has no driver here
    assign link.sdaSOut = 1'b0;
    assign link.sdaSOe = sdaDrv_q;
    assign configWord = config_q;
    assign lowerLimit = lower_q;
    assign upperLimit = upper_q;
    assign powerDown = pd_q;
    assign hsMode = hs_q;
endmodule

// ===== verilog/i2sp_master.sv
// two-wire bus master with an APB register front end
`timescale 1ns/1ps
module i2sp_master
    import i2sp_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    i2sp_link_if.master link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    i2sp_master_state_t state_q;
    logic [5:0] ctrl_q;
    logic [7:0] txData_q, rxData_q, shift_q;
    logic [15:0] div_q, cnt_q;
    logic [1:0] phase_q;
    logic [3:0] bitCnt_q;
    logic busy_q, ackBad_q, sclDrv_q, sdaDrv_q;
    logic [1:0] sdaSync_q;
    logic wrEn, tick, known;

    assign pready = 1'b1;
    assign wrEn = psel & penable & pwrite;
    assign known = paddr == REG_CTRL || paddr == REG_DATA || paddr == REG_STATUS ||
        paddr == REG_RDATA || paddr == REG_DIV;
    assign pslverr = psel & penable & ~known;
    assign tick = cnt_q == 16'h0000;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            prdata <= 32'h00000000;
        else if (psel && !penable) begin
            case (paddr)
                REG_CTRL: prdata <= {26'h0000000, ctrl_q};
                REG_DATA: prdata <= {24'h000000, txData_q};
                REG_STATUS: prdata <= {30'h00000000, ackBad_q, busy_q};
                REG_RDATA: prdata <= {24'h000000, rxData_q};
                REG_DIV: prdata <= {16'h0000, div_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            txData_q <= 8'h00;
            div_q <= DIV_RESET;
        end else if (wrEn && !busy_q) begin
            if (paddr == REG_DATA)
                txData_q <= pwdata[7:0];
            if (paddr == REG_DIV)
                div_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            sdaSync_q <= 2'h3;
        else
            sdaSync_q <= {sdaSync_q[0], link.sda};
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            cnt_q <= 16'h0000;
        else if (tick || state_q == MS_IDLE)
            cnt_q <= div_q;
        else
            cnt_q <= cnt_q - 16'h0001;
    end

    // each bit takes four ticks: low-set, rise, high-sample, fall
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= MS_IDLE;
            ctrl_q <= 6'h00;
            busy_q <= 1'b0;
            ackBad_q <= 1'b0;
            sclDrv_q <= 1'b0;
            sdaDrv_q <= 1'b0;
            phase_q <= 2'h0;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            rxData_q <= 8'h00;
        end else begin
            case (state_q)
                MS_IDLE: begin
                    if (wrEn && paddr == REG_CTRL && pwdata[CTRL_GO] && !busy_q) begin
                        ctrl_q <= pwdata[5:0];
                        busy_q <= 1'b1;
                        phase_q <= 2'h0;
                        bitCnt_q <= 4'h0;
                        shift_q <= pwdata[CTRL_READ] ? 8'hff : txData_q;
                        state_q <= pwdata[CTRL_START] ? MS_START : MS_BIT;
                    end
                end
                MS_START: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        2'h0: begin
                            sdaDrv_q <= 1'b0;
                            sclDrv_q <= 1'b0;
                        end
                        2'h1: sdaDrv_q <= 1'b1;
                        2'h2: sclDrv_q <= 1'b1;
                        default: state_q <= MS_BIT;
                    endcase
                end
                MS_BIT, MS_ACK: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        2'h0: begin
                            if (state_q == MS_BIT)
                                sdaDrv_q <= ~shift_q[7];
                            else
                                sdaDrv_q <= ctrl_q[CTRL_READ] & ~ctrl_q[CTRL_NACK];
                        end
                        2'h1: sclDrv_q <= 1'b0;
                        2'h2: begin
                            if (state_q == MS_BIT)
                                shift_q <= {shift_q[6:0], sdaSync_q[1]};
                            else if (!ctrl_q[CTRL_READ])
                                ackBad_q <= sdaSync_q[1];
                        end
                        default: begin
                            sclDrv_q <= 1'b1;
                            if (state_q == MS_ACK) begin
                                sdaDrv_q <= 1'b0;
                                rxData_q <= shift_q;
                                state_q <= ctrl_q[CTRL_STOP] ? MS_STOP : MS_DONE;
                            end else if (bitCnt_q == 4'h7) begin
                                sdaDrv_q <= 1'b0;
                                state_q <= MS_ACK;
                            end else
                                bitCnt_q <= bitCnt_q + 4'h1;
                        end
                    endcase
                end
                MS_STOP: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        2'h0: sdaDrv_q <= 1'b1;
                        2'h1: sclDrv_q <= 1'b0;
                        2'h2: sdaDrv_q <= 1'b0;
                        default: state_q <= MS_DONE;
                    endcase
                end
                MS_DONE: begin
                    busy_q <= 1'b0;
                    state_q <= MS_IDLE;
                end
                default: state_q <= MS_IDLE;
            endcase
        end
    end

    assign link.sclOut = 1'b0;
    assign link.sclOe = sclDrv_q;
    assign link.sdaMOut = 1'b0;
    assign link.sdaMOe = sdaDrv_q;
endmodule

// ===== sim/i2sp_link_props.sv
// link checker for the register port and its bus master
`timescale 1ns/1ps
module i2sp_link_props (
    input wire logic clock,
    input wire logic rstn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaMOut,
    input wire logic sdaMOe,
    input wire logic sdaSOut,
    input wire logic sdaSOe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_open; sdaSOut == 1'b0 && sdaMOut == 1'b0 && sclOut == 1'b0; endproperty
    a_open: assert property (p_open) else $error("link driven high");
    property p_clk; !sclOe |-> scl; endproperty
    a_clk: assert property (p_clk) else $error("clock held low by target");
    property p_on; $rose(sdaSOe) |-> !scl && !$past(scl); endproperty
    a_on: assert property (p_on) else $error("target drove data while clock high");
    property p_off; $fell(sdaSOe) |-> !scl; endproperty
    a_off: assert property (p_off) else $error("target let go while clock high");
    property p_hold; $rose(sdaSOe) |=> sdaSOe [*8]; endproperty
    a_hold: assert property (p_hold) else $error("target bit too short");
    // the master may take the line a few clocks before the synchronised target lets go
    property p_clash; sdaSOe && sdaMOe |-> ##[1:6] (!sdaSOe || !sdaMOe); endproperty
    a_clash: assert property (p_clash) else $error("both ends pull data too long");
    property p_stop; scl && $rose(sda) |=> !sdaSOe [*8]; endproperty
    a_stop: assert property (p_stop) else $error("target drove after stop");
    property p_start; scl && $fell(sda) |=> !sdaSOe [*8]; endproperty
    a_start: assert property (p_start) else $error("target drove after start");
endmodule

// ===== sim/test_i2c_slave_register_port.sv
// self-checking bench: bus master and register port joined over the link
`timescale 1ns/1ps
module test_i2c_slave_register_port
    import i2sp_pkg::*;
;
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
    localparam logic [5:0] C_GO = 6'h01 << CTRL_GO;
    localparam logic [5:0] C_ST = C_GO | (6'h01 << CTRL_START);
    localparam logic [5:0] C_SP = C_GO | (6'h01 << CTRL_STOP);
    localparam logic [5:0] C_RD = C_GO | (6'h01 << CTRL_READ);
    localparam logic [5:0] C_RL = C_RD | C_SP | (6'h01 << CTRL_NACK);
    logic clock, pready, pslverr, slvErr, powerDown, hsMode;
    logic rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, resultValid = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [1:0] strapSel = STRAP_GND;
    logic signed [17:0] resultRaw = 18'h0;
    logic [15:0] configWord, lowerLimit, upperLimit;
    int err_count = 0;
    int tests_run = 0;
    logic [17:0] regRows [3] = '{{IDX_CONFIG, 16'h4221}, {IDX_LOWER, 16'h1234},
        {IDX_UPPER, 16'hfedc}};
    logic [33:0] resRows [6] = '{{18'h00001, 16'h0001}, {18'h3ffff, 16'hffff},
        {18'h07fff, 16'h7fff}, {18'h08000, 16'h7fff}, {18'h38000, 16'h8000},
        {18'h37fff, 16'h8000}};
    i2sp_link_if i2sp_link_if_inst ();
    i2sp_master i2sp_master_inst (.clock(clock), .rstn(rstn), .link(i2sp_link_if_inst.master),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    i2sp_slave i2sp_slave_inst (.clock(clock), .rstn(rstn), .link(i2sp_link_if_inst.slave),
        .strapSel(strapSel), .resultValid(resultValid), .resultRaw(resultRaw),
        .configWord(configWord), .lowerLimit(lowerLimit), .upperLimit(upperLimit),
        .powerDown(powerDown), .hsMode(hsMode));
    i2sp_link_props i2sp_link_props_inst (.clock(clock), .rstn(rstn),
        .sclOut(i2sp_link_if_inst.sclOut), .sclOe(i2sp_link_if_inst.sclOe),
        .sdaMOut(i2sp_link_if_inst.sdaMOut), .sdaMOe(i2sp_link_if_inst.sdaMOe),
        .sdaSOut(i2sp_link_if_inst.sdaSOut), .sdaSOe(i2sp_link_if_inst.sdaSOe),
        .scl(i2sp_link_if_inst.scl), .sda(i2sp_link_if_inst.sda));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic [5:0] c, input logic [7:0] d, output logic [7:0] rx,
        output logic nak);
        logic [31:0] r;
        apb(1'b1, REG_DATA, {24'h0, d}, r);
        apb(1'b1, REG_CTRL, {26'h0, c}, r);
        r = 32'h1;
        while (r[0] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0, r);
        nak = r[1];
        apb(1'b0, REG_RDATA, 32'h0, r);
        rx = r[7:0];
    endtask
    task automatic wr(input logic [1:0] idx, input logic [15:0] v, input logic full);
        logic [7:0] rx;
        logic k;
        op(C_ST, {ADDR_BASE, 1'b0}, rx, k);
        `CHK("write addr ack", 1'b0, k)
        op(full ? C_GO : C_SP, {6'h00, idx}, rx, k);
        `CHK("pointer ack", 1'b0, k)
        if (full) begin
            op(C_GO, v[15:8], rx, k);
            `CHK("high byte ack", 1'b0, k)
            op(C_SP, v[7:0], rx, k);
            `CHK("low byte ack", 1'b0, k)
        end
    endtask
    task automatic rd(output logic [15:0] v);
        logic k;
        op(C_ST, {ADDR_BASE, 1'b1}, v[15:8], k);
        `CHK("read addr ack", 1'b0, k)
        op(C_RD, 8'hff, v[15:8], k);
        op(C_RL, 8'hff, v[7:0], k);
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        #700_000;
        err_count++;
        give_verdict();
    end
    initial begin
        logic [31:0] r;
        logic [15:0] v;
        logic [7:0] rx;
        logic k;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, REG_DIV, 32'h0, r);
        `CHK("divider reset", {16'h0, DIV_RESET}, r)
        `CHK("config reset", CONFIG_RESET, configWord)
        `CHK("lower reset", LOWER_RESET, lowerLimit)
        `CHK("upper reset", UPPER_RESET, upperLimit)
        `CHK("power down reset", 1'b1, powerDown)
        `CHK("fast filter reset", 1'b0, hsMode)
        // a short divider the target can still follow keeps the run short
        apb(1'b1, REG_DIV, 32'h14, r);
        rd(v);
        `CHK("result at power-up", RESULT_RESET, v)
        $display("reset test done");
        foreach (regRows[i]) begin
            wr(regRows[i][17:16], regRows[i][15:0], 1'b1);
            case (regRows[i][17:16])
                IDX_CONFIG: v = configWord;
                IDX_LOWER: v = lowerLimit;
                default: v = upperLimit;
            endcase
            `CHK("register port", regRows[i][15:0], v)
            rd(v);
            `CHK("register readback", regRows[i][15:0], v)
        end
        `CHK("config mode bit", 1'b0, powerDown)
        wr(IDX_RESULT, 16'h0, 1'b0);
        foreach (resRows[i]) begin
            @(posedge clock);
            resultValid <= 1'b1;
            resultRaw <= resRows[i][33:16];
            @(posedge clock);
            resultValid <= 1'b0;
            rd(v);
            `CHK("result code", resRows[i][15:0], v)
        end
        $display("table tests done");
        op(C_ST, {ADDR_BASE, 1'b1}, rx, k);
        op(C_RL, 8'hff, rx, k);
        `CHK("one byte read", resRows[5][15:8], rx)
        rd(v);
        `CHK("read after early end", resRows[5][15:0], v)
        // result now 8000: first data bit is a one, so the stop right after the ack can land
        for (int s = 0; s < 4; s++) begin
            strapSel <= 2'(s);
            repeat (4) @(posedge clock);
            op(C_ST | C_SP, {ADDR_BASE + 7'(s), 1'b1}, rx, k);
            `CHK("strap address ack", 1'b0, k)
            op(C_ST | C_SP, {ADDR_BASE + 7'(s + 1), 1'b1}, rx, k);
            `CHK("other address refused", 1'b1, k)
        end
        strapSel <= STRAP_GND;
        op(C_ST, 8'h09, rx, k);
        `CHK("master code refused", 1'b1, k)
        `CHK("fast filter on", 1'b1, hsMode)
        wr(IDX_UPPER, 16'h0, 1'b0);
        `CHK("fast filter off", 1'b0, hsMode)
        op(C_ST, {GEN_CALL_ADDR, 1'b0}, rx, k);
        `CHK("general call ack", 1'b0, k)
        op(C_SP, GEN_CALL_RESET, rx, k);
        `CHK("reset command ack", 1'b0, k)
        `CHK("config restored", CONFIG_RESET, configWord)
        `CHK("upper restored", UPPER_RESET, upperLimit)
        `CHK("powered down", 1'b1, powerDown)
        rd(v);
        `CHK("result cleared", RESULT_RESET, v)
        apb(1'b0, 8'h20, 32'h0, r);
        `CHK("unmapped slave error", 1'b1, slvErr)
        $display("awkward tests done");
        give_verdict();
    end
endmodule
